// ### ppmc_params.svh
// Register offsets, field positions, reset values and codes of the port mode control block
`ifndef PPMC_PARAMS_SVH
`define PPMC_PARAMS_SVH
`define PPMC_OFF_CTRL 8'h00
`define PPMC_OFF_DIR 8'h04
`define PPMC_OFF_STATUS 8'h08
`define PPMC_OFF_CLEAR 8'h0c
`define PPMC_OFF_ENABLE 8'h10
`define PPMC_OFF_DATA 8'h14
`define PPMC_OFF_CFG_A 8'h18
`define PPMC_OFF_CFG_B 8'h1c
`define PPMC_OFF_FIFO 8'h20
`define PPMC_MODE_MSB 7
`define PPMC_MODE_LSB 5
`define PPMC_FIRQ_BIT 4
`define PPMC_DMA_REQUEST_ENABLE_BIT 3
`define PPMC_SVC_BIT 2
`define PPMC_CTRL_RESET 8'h14
`define PPMC_CFG_A_VALUE 8'h10
`define PPMC_CFG_B_RESET 8'h07
`define PPMC_ST_FAULT 0
`define PPMC_ST_TC 1
`define PPMC_RESP_OKAY 2'b00
`define PPMC_RESP_SLVERR 2'b10
`endif

// ### ppmc_pkg.sv
// Types of the port mode control block
package ppmc_pkg;
  typedef enum logic [2:0] {
    PPMC_MODE_COMPAT = 3'b000,
    PPMC_MODE_BIDIR = 3'b001,
    PPMC_MODE_FIFO = 3'b010,
    PPMC_MODE_ECP = 3'b011,
    PPMC_MODE_EPP = 3'b100,
    PPMC_MODE_RSVD = 3'b101,
    PPMC_MODE_TEST = 3'b110,
    PPMC_MODE_CONFIG = 3'b111
  } ppmc_mode_t;
  typedef struct packed {
    logic [7:0] data_out;
    logic [7:0] data_oe_n;
    logic fifo_flush;
    logic fifo_to_port;
    logic fifo_from_port;
    logic ecp_active;
    logic epp_active;
    logic dma_req;
  } ppmc_port_ctl_t;
endpackage : ppmc_pkg

// ### ppmc_top.sv
// Extended port control register bank with AXI4-Lite slave
// Function
// - Three-bit mode field in bits 7-5 is readable, writable, selects port mode.
// - Mode 000 is compatibility port; FIFO held flushed while selected.
// - Mode 001 lets direction float the eight data drivers.
// - In mode 001 data reads return the data line levels.
// - Mode 010 sends FIFO bytes with compatibility handshake, forward only.
// - Mode 011 forward: data and address queues share one FIFO, sent by ECP.
// - Mode 011 reverse: bytes from peripheral enter the data queue.
// - Mode 100 enables EPP only when configuration also selects EPP.
// - Mode 110 lets host use FIFO without sending on the port.
// - Mode 111 exposes configuration registers A and B; hidden otherwise.
// - Disable bit 0 in ECP mode: interrupt on falling fault edge.
// - Fault interrupt is edge captured, never lost between read and write; code drops an edge seen while disable bit is 1, even after it is cleared.
// - Disable bit 1 suppresses the fault interrupt; bit is read/write.
// - DMA enable 0 blocks every DMA request; 1 permits DMA.
// - With DMA enabled, terminal count sets the service flag.
// - Direction 0 is forward, 1 is reverse into the FIFO.
//
// Added by the designer: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/100ps
`include "ppmc_params.svh"
module ppmc_top
  import ppmc_pkg::*;
#(
  parameter bit EPP_CONFIGURED = 1'b1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // AXI4-Lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Port side
  input wire logic [7:0] data_lines_in,
  input wire logic peripheral_fault_n,
  input wire logic dma_terminal_count,
  input wire logic fifo_request,
  output ppmc_port_ctl_t port_ctl,
  // Interrupt
  output logic irq
);

  logic [7:0] ctrl_q;
  logic direction_q;
  logic [7:0] data_q;
  logic [7:0] cfg_b_q;
  logic [7:0] fifo_reg_q;
  logic [1:0] status_q;
  logic [1:0] enable_q;
  logic [2:0] fault_sync_q;
  logic fault_level_q;
  logic [7:0] lines_s1_q;
  logic [7:0] lines_s2_q;
  logic [7:0] lines_s3_q;
  logic [7:0] lines_level_q;
  logic [7:0] lines_level_d;
  logic aw_held_q;
  logic w_held_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  ppmc_mode_t mode;
  logic do_write;
  logic fault_fall;
  logic [1:0] clear_bits;
  logic fault_set;
  logic tc_set;

  // Mode decode from the control register
  assign mode = ppmc_mode_t'(ctrl_q[`PPMC_MODE_MSB:`PPMC_MODE_LSB]);

  function automatic logic is_hit(input logic [7:0] a, input logic [7:0] off);
    is_hit = (a[7:2] == off[7:2]);
  endfunction : is_hit

  function automatic logic cfg_visible(input ppmc_mode_t m, input logic [7:0] a);
    cfg_visible = (m == PPMC_MODE_CONFIG) &&
      (is_hit(a, `PPMC_OFF_CFG_A) || is_hit(a, `PPMC_OFF_CFG_B));
  endfunction : cfg_visible

  // Offsets that accept a write in the current mode
  function automatic logic wr_mapped(input ppmc_mode_t m, input logic [7:0] a);
    if (is_hit(a, `PPMC_OFF_CTRL) || is_hit(a, `PPMC_OFF_DIR) || is_hit(a, `PPMC_OFF_CLEAR)) begin
      wr_mapped = 1'b1;
    end else if (is_hit(a, `PPMC_OFF_ENABLE) || is_hit(a, `PPMC_OFF_DATA) || is_hit(a, `PPMC_OFF_FIFO)) begin
      wr_mapped = 1'b1;
    end else begin
      wr_mapped = cfg_visible(m, a);
    end
  endfunction : wr_mapped

  // Modes that move FIFO bytes over the port
  function automatic logic fifo_path(input ppmc_mode_t m);
    fifo_path = (m == PPMC_MODE_FIFO) || (m == PPMC_MODE_ECP);
  endfunction : fifo_path

  // Write channel capture, either order
  assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
  assign s_axi_wready = !w_held_q && !s_axi_bvalid;
  assign do_write = aw_held_q && w_held_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end else if (do_write) begin
        w_held_q <= 1'b0;
      end
    end
  end

  // Write response
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PPMC_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      if (wr_mapped(mode, aw_addr_q)) begin
        s_axi_bresp <= `PPMC_RESP_OKAY;
      end else begin
        s_axi_bresp <= `PPMC_RESP_SLVERR;
      end
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Control, direction, data, configuration B and test FIFO registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_q <= `PPMC_CTRL_RESET;
      direction_q <= 1'b0;
      data_q <= 8'h00;
      cfg_b_q <= `PPMC_CFG_B_RESET;
      fifo_reg_q <= 8'h00;
    end else if (do_write && w_strb_q[0]) begin
      if (is_hit(aw_addr_q, `PPMC_OFF_CTRL)) begin
        ctrl_q[7:3] <= w_data_q[7:3];
      end else if (is_hit(aw_addr_q, `PPMC_OFF_DIR)) begin
        direction_q <= w_data_q[0];
      end else if (is_hit(aw_addr_q, `PPMC_OFF_DATA)) begin
        data_q <= w_data_q[7:0];
      end else if (cfg_visible(mode, aw_addr_q) && is_hit(aw_addr_q, `PPMC_OFF_CFG_B)) begin
        cfg_b_q[2:0] <= w_data_q[2:0];
      end else if (is_hit(aw_addr_q, `PPMC_OFF_FIFO) && mode != PPMC_MODE_COMPAT) begin
        fifo_reg_q <= w_data_q[7:0];
      end
    end else if (mode == PPMC_MODE_COMPAT) begin
      fifo_reg_q <= 8'h00;
    end
  end

  // Pin synchronisers, change counts once stages two and three agree
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fault_sync_q <= 3'b111;
      fault_level_q <= 1'b1;
      lines_s1_q <= 8'h00;
      lines_s2_q <= 8'h00;
      lines_s3_q <= 8'h00;
      lines_level_q <= 8'h00;
    end else begin
      fault_sync_q <= {fault_sync_q[1:0], peripheral_fault_n};
      if (fault_sync_q[1] == fault_sync_q[2]) begin
        fault_level_q <= fault_sync_q[2];
      end
      lines_s1_q <= data_lines_in;
      lines_s2_q <= lines_s1_q;
      lines_s3_q <= lines_s2_q;
      lines_level_q <= lines_level_d;
    end
  end

  // Per data line, a change counts once stages two and three agree
  for (genvar gi = 0; gi < 8; gi++) begin : g_line_agree
    assign lines_level_d[gi] = (lines_s2_q[gi] == lines_s3_q[gi]) ? lines_s3_q[gi] : lines_level_q[gi];
  end

  // Falling edge: agreed level was high, newly agreed level is low
  assign fault_fall = fault_level_q && (fault_sync_q[1] == fault_sync_q[2]) && !fault_sync_q[2];

  // Status set events, fault only in ECP mode with the interrupt allowed
  assign fault_set = fault_fall && (mode == PPMC_MODE_ECP) && !ctrl_q[`PPMC_FIRQ_BIT];
  assign tc_set = dma_terminal_count && ctrl_q[`PPMC_DMA_REQUEST_ENABLE_BIT];

  // Sticky status; set wins over clear
  assign clear_bits = (do_write && w_strb_q[0] && is_hit(aw_addr_q, `PPMC_OFF_CLEAR)) ?
    w_data_q[1:0] : 2'b00;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      status_q <= 2'b00;
    end else begin
      status_q[`PPMC_ST_FAULT] <= fault_set || (status_q[`PPMC_ST_FAULT] && !clear_bits[`PPMC_ST_FAULT]);
      status_q[`PPMC_ST_TC] <= tc_set || (status_q[`PPMC_ST_TC] && !clear_bits[`PPMC_ST_TC]);
    end
  end

  // Interrupt enable register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      enable_q <= 2'b00;
    end else if (do_write && w_strb_q[0] && is_hit(aw_addr_q, `PPMC_OFF_ENABLE)) begin
      enable_q <= w_data_q[1:0];
    end
  end

  // Level interrupt from enabled status bits
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_q & enable_q);
    end
  end

  // Read channel
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `PPMC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `PPMC_RESP_OKAY;
      s_axi_rdata <= 32'h0000_0000;
      if (is_hit(s_axi_araddr, `PPMC_OFF_CTRL)) begin
        s_axi_rdata[7:0] <= {ctrl_q[7:3], ctrl_q[`PPMC_DMA_REQUEST_ENABLE_BIT] & status_q[`PPMC_ST_TC], 2'b00};
      end else if (is_hit(s_axi_araddr, `PPMC_OFF_DIR)) begin
        s_axi_rdata[0] <= direction_q;
      end else if (is_hit(s_axi_araddr, `PPMC_OFF_STATUS)) begin
        s_axi_rdata[1:0] <= status_q;
      end else if (is_hit(s_axi_araddr, `PPMC_OFF_CLEAR)) begin
        s_axi_rdata <= 32'h0000_0000;
      end else if (is_hit(s_axi_araddr, `PPMC_OFF_ENABLE)) begin
        s_axi_rdata[1:0] <= enable_q;
      end else if (is_hit(s_axi_araddr, `PPMC_OFF_DATA)) begin
        s_axi_rdata[7:0] <= (mode == PPMC_MODE_BIDIR) ? lines_level_q : data_q;
      end else if (cfg_visible(mode, s_axi_araddr) && is_hit(s_axi_araddr, `PPMC_OFF_CFG_A)) begin
        s_axi_rdata[7:0] <= `PPMC_CFG_A_VALUE;
      end else if (cfg_visible(mode, s_axi_araddr)) begin
        s_axi_rdata[7:0] <= cfg_b_q;
      end else if (is_hit(s_axi_araddr, `PPMC_OFF_FIFO)) begin
        s_axi_rdata[7:0] <= fifo_reg_q;
      end else begin
        s_axi_rresp <= `PPMC_RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Port control outputs
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      port_ctl <= '{data_out: 8'h00, data_oe_n: 8'h00, default: 1'b0};
    end else begin
      port_ctl.data_out <= data_q;
      port_ctl.data_oe_n <= {8{direction_q && mode != PPMC_MODE_COMPAT}};
      port_ctl.fifo_flush <= (mode == PPMC_MODE_COMPAT) || (mode == PPMC_MODE_RSVD);
      port_ctl.fifo_to_port <= !direction_q && fifo_path(mode);
      port_ctl.fifo_from_port <= direction_q && mode == PPMC_MODE_ECP;
      port_ctl.ecp_active <= mode == PPMC_MODE_ECP;
      port_ctl.epp_active <= mode == PPMC_MODE_EPP && EPP_CONFIGURED;
      port_ctl.dma_req <= ctrl_q[`PPMC_DMA_REQUEST_ENABLE_BIT] && fifo_request && !status_q[`PPMC_ST_TC] &&
        (fifo_path(mode) || mode == PPMC_MODE_TEST);
    end
  end

endmodule : ppmc_top

// ### ppmc_top_sva.sv
// Checker for the port mode control register bank
`timescale 1ns/100ps
module ppmc_top_sva
  import ppmc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Port side
  input wire logic fifo_request,
  input wire ppmc_port_ctl_t port_ctl
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  a_write_answer:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_bresp_hold:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("write response dropped");
  a_read_answer:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read data late");
  a_rdata_hold:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  a_read_refuse:
    assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken while answer pending");
  a_flush_ecp:
    assert property (port_ctl.ecp_active |-> !port_ctl.fifo_flush) else $error("fifo flushed in ecp mode");
  a_reverse_ecp:
    assert property (port_ctl.fifo_from_port |-> port_ctl.ecp_active && !port_ctl.fifo_to_port)
    else $error("reverse fill outside ecp");
  a_epp_alone:
    assert property (port_ctl.epp_active |-> !port_ctl.ecp_active && !port_ctl.fifo_flush)
    else $error("epp mixed with other mode");
  a_oe_whole:
    assert property (port_ctl.data_oe_n == 8'h00 || port_ctl.data_oe_n == 8'hff) else $error("split data enable");
  a_dma_request:
    assert property (port_ctl.dma_req |-> $past(fifo_request) && !port_ctl.fifo_flush)
    else $error("dma request without cause");
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_reverse: cover property (port_ctl.fifo_from_port);
  c_dma: cover property (port_ctl.dma_req);
endmodule : ppmc_top_sva
bind ppmc_top ppmc_top_sva u_sva (.clk(clk), .rst_n(rst_n), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .fifo_request(fifo_request), .port_ctl(port_ctl));

// ### ppmc_periph.sv
// Peripheral model driving the data lines and the fault line
`timescale 1ns/100ps
module ppmc_periph (
  // Clock and commands
  input wire logic clk,
  input wire logic drive_en,
  input wire logic [7:0] drive_val,
  input wire logic fault_on,
  // Port lines
  output logic [7:0] data_lines,
  output logic fault_n
);
  initial data_lines = 8'h00;
  initial fault_n = 1'b1;
  // Released lines change every cycle
  always @(posedge clk) begin
    data_lines <= drive_en ? drive_val : ~data_lines;
    fault_n <= ~fault_on;
  end
endmodule : ppmc_periph

// ### parallel_port_mode_control_test.sv
// Self-checking bench for the port mode control register bank
`timescale 1ns/100ps
`include "ppmc_params.svh"
module parallel_port_mode_control_test import ppmc_pkg::*;;
  logic clk, awready, wready, bvalid, arready, rvalid, irq, fault_n;
  logic rst_n = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic den = 1'b0, fon = 1'b0, tc = 1'b0, freq = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, dv = 8'h00, dl;
  logic [31:0] wdata = 32'h0, rdata, q;
  logic [1:0] bresp, rresp, r;
  ppmc_port_ctl_t pc;
  int errors = 0, tests_run = 0, cyc = 0;
  ppmc_top dut (.clk(clk), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .data_lines_in(dl),
    .peripheral_fault_n(fault_n), .dma_terminal_count(tc), .fifo_request(freq), .port_ctl(pc), .irq(irq));
  ppmc_periph peer (.clk(clk), .drive_en(den), .drive_val(dv), .fault_on(fon), .data_lines(dl), .fault_n(fault_n));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic finish_test();
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : finish_test
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      errors++;
      finish_test();
    end
  end
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  // One bus transfer; handshakes sampled at the rising edge, released right after it
  task automatic xfer(input bit w, input logic [7:0] a, input logic [31:0] d);
    bit done;
    done = 1'b0;
    @(posedge clk);
    if (w) begin
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
    end else begin
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
    end
    while (!done) begin
      @(posedge clk);
      done = w ? bvalid : rvalid;
      q = rdata;
      r = w ? bresp : rresp;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (arvalid && arready) arvalid <= 1'b0;
      if (done) bready <= 1'b0;
      if (done) rready <= 1'b0;
    end
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
    xfer(1'b1, a, d);
    chk("bresp", r, er);
  endtask : wr
  task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = 2'h0);
    xfer(1'b0, a, 32'h0);
    chk("resp", r, er);
    if (er == 2'h0) chk("rdata", q, e);
  endtask : rc
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    rc(`PPMC_OFF_CTRL, 32'h10);
    wr(`PPMC_OFF_FIFO, 32'h77);
    rc(`PPMC_OFF_FIFO, 32'h0);
    for (int m = 0; m < 8; m++) begin
      if (m != 5) begin
        wr(`PPMC_OFF_CTRL, {24'h0, m[2:0], 5'h10});
        rc(`PPMC_OFF_CTRL, {24'h0, m[2:0], 5'h10});
        chk("flush", pc.fifo_flush, m == 0);
        chk("ecp", pc.ecp_active, m == 3);
        chk("epp", pc.epp_active, m == 4);
        chk("tx", pc.fifo_to_port, m == 2 || m == 3);
      end
    end
    rc(`PPMC_OFF_CFG_A, 32'h10);
    rc(`PPMC_OFF_CFG_B, 32'h07);
    wr(`PPMC_OFF_FIFO, 32'h77);
    rc(`PPMC_OFF_FIFO, 32'h77);
    wr(`PPMC_OFF_DATA, 32'h3c);
    rc(`PPMC_OFF_DATA, 32'h3c);
    chk("dout", pc.data_out, 8'h3c);
    wr(`PPMC_OFF_CTRL, 32'h30);
    wr(`PPMC_OFF_DIR, 32'h1);
    rc(`PPMC_OFF_DIR, 32'h1);
    den <= 1'b1;
    dv <= 8'ha5;
    rc(`PPMC_OFF_CFG_A, 32'h0, 2'h2);
    rc(8'h40, 32'h0, 2'h2);
    wr(`PPMC_OFF_CFG_B, 32'h0, 2'h2);
    chk("oe", pc.data_oe_n, 8'hff);
    rc(`PPMC_OFF_DATA, 32'ha5);
    den <= 1'b0;
    wr(`PPMC_OFF_ENABLE, 32'h1);
    wr(`PPMC_OFF_CTRL, 32'h60);
    rc(`PPMC_OFF_CTRL, 32'h60);
    chk("rev", pc.fifo_from_port, 1'b1);
    chk("fwd", pc.fifo_to_port, 1'b0);
    fon <= 1'b1;
    repeat (8) @(posedge clk);
    chk("irq", irq, 1'b1);
    fon <= 1'b0;
    rc(`PPMC_OFF_STATUS, 32'h1);
    wr(`PPMC_OFF_CLEAR, 32'h1);
    repeat (2) @(posedge clk);
    chk("irq", irq, 1'b0);
    wr(`PPMC_OFF_CTRL, 32'h70);
    fon <= 1'b1;
    repeat (8) @(posedge clk);
    rc(`PPMC_OFF_STATUS, 32'h0);
    chk("irq", irq, 1'b0);
    freq <= 1'b1;
    wr(`PPMC_OFF_CTRL, 32'h40);
    rc(`PPMC_OFF_CTRL, 32'h40);
    chk("dma", pc.dma_req, 1'b0);
    wr(`PPMC_OFF_CTRL, 32'h48);
    repeat (2) @(posedge clk);
    chk("dma", pc.dma_req, 1'b1);
    tc <= 1'b1;
    @(posedge clk);
    tc <= 1'b0;
    rc(`PPMC_OFF_CTRL, 32'h4c);
    chk("dma", pc.dma_req, 1'b0);
    finish_test();
  end
endmodule : parallel_port_mode_control_test
